// [hw/cdio_port.sv]
// Purpose: I/O register decode for three timer channels and 24 DIO lines
// Assumes: asynchronous bus strobes and pins, sampled on REF_CLK (125 MHz)
// Notes:   counting inside each mode is done elsewhere from TIMER_CFG
`include "cdio_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - decode eight addresses at base, nothing else
// - offsets 0-2 give byte access to timers
// - offset 3 takes the timer control word
// - selector picks channel, 11 means read-back
// - format: latch, low, high, low then high
// - mode field selects one of six modes
// - bit 0 picks binary or decimal counting
// - offsets 4-6 are port data registers
// - offset 7 is write-only direction register
// - output ports drive last written value
// - input ports read the line levels
// - port C split into two nibbles
// - direction bits one input, zero output
// - 0x92 makes A, B inputs, C outputs
// - plain latched output and direct input only
// - all ports undriven after reset
// - outputs held in register, inputs unlatched
module cdio_port
(
    input  wire logic                         REF_CLK,  // system clock
    input  wire logic                         RESET,    // async, active high
    input  wire logic [9:0]                   SA,       // bus address
    input  wire logic [6:0]                   BASE_SEL, // base switches A9..A3
    input  wire logic                         IOR_N,    // read strobe, low
    input  wire logic                         IOW_N,    // write strobe, low
    input  wire logic [7:0]                   SD_IN,    // data bus in
    output logic [7:0]                        SD_OUT,   // data bus out
    output logic                              SD_OE,    // data bus drive
    input  wire logic [7:0]                   FIRST_PORT_LINES_IN,  // A in
    output logic [7:0]                        FIRST_PORT_LINES_OUT, // A out
    output logic [7:0]                        FIRST_PORT_LINES_OE,  // A oe
    input  wire logic [7:0]                   SECOND_PORT_LINES_IN, // B in
    output logic [7:0]                        SECOND_PORT_LINES_OUT,// B out
    output logic [7:0]                        SECOND_PORT_LINES_OE, // B oe
    input  wire logic [7:0]                   THIRD_PORT_LINES_IN,  // C in
    output logic [7:0]                        THIRD_PORT_LINES_OUT, // C out
    output logic [7:0]                        THIRD_PORT_LINES_OE,  // C oe
    output cdio_pkg::cdio_tcfg_t [2:0]        TIMER_CFG // per-channel config
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // mode field to mode; top bit ignored for x10 and x11
    function automatic cdio_pkg::cdio_mode_t dec_mode(input logic [2:0] m);
        cdio_pkg::cdio_mode_t r;
        r = cdio_pkg::CDIO_M_TC_INT;
        case (m)
            3'h0:    r = cdio_pkg::CDIO_M_TC_INT;
            3'h1:    r = cdio_pkg::CDIO_M_ONESHOT;
            3'h2:    r = cdio_pkg::CDIO_M_RATE;
            3'h6:    r = cdio_pkg::CDIO_M_RATE;
            3'h3:    r = cdio_pkg::CDIO_M_SQUARE;
            3'h7:    r = cdio_pkg::CDIO_M_SQUARE;
            3'h4:    r = cdio_pkg::CDIO_M_SW_STROBE;
            3'h5:    r = cdio_pkg::CDIO_M_HW_STROBE;
            default: r = cdio_pkg::CDIO_M_TC_INT;
        endcase
        return r;
    endfunction

    // per-line mix of driven value and sampled pin level
    function automatic logic [7:0] mix(input logic [7:0] o,
                                       input logic [7:0] i,
                                       input logic [7:0] oe);
        return (o & oe) | (i & ~oe);
    endfunction

    // freeze the loaded divisor unless a latch is already pending
    function automatic cdio_pkg::cdio_chan_t do_latch(
        input cdio_pkg::cdio_chan_t c);
        cdio_pkg::cdio_chan_t r;
        r = c;
        if (!c.latched)
        begin
            r.latch   = c.cfg.divisor;
            r.latched = 1'b1;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [9:0] sa_s1_r,  sa_s2_r;    // address
    logic [6:0] bs_s1_r,  bs_s2_r;    // base switches
    logic [7:0] sd_s1_r,  sd_s2_r;    // write data
    logic [2:0] ior_r,    iow_r;      // strobe sync plus edge stage
    logic [7:0] pa_s1_r,  pa_s2_r;    // port A pins
    logic [7:0] pb_s1_r,  pb_s2_r;    // port B pins
    logic [7:0] pc_s1_r,  pc_s2_r;    // port C pins

    // two flops on every pin; strobes get a third stage for the edge
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sa_s1_r <= 10'h000;
            sa_s2_r <= 10'h000;
            bs_s1_r <= 7'h00;
            bs_s2_r <= 7'h00;
            sd_s1_r <= 8'h00;
            sd_s2_r <= 8'h00;
            ior_r   <= 3'h7;
            iow_r   <= 3'h7;
            pa_s1_r <= 8'h00;
            pa_s2_r <= 8'h00;
            pb_s1_r <= 8'h00;
            pb_s2_r <= 8'h00;
            pc_s1_r <= 8'h00;
            pc_s2_r <= 8'h00;
        end
        else
        begin
            sa_s1_r <= SA;
            sa_s2_r <= sa_s1_r;
            bs_s1_r <= BASE_SEL;
            bs_s2_r <= bs_s1_r;
            sd_s1_r <= SD_IN;
            sd_s2_r <= sd_s1_r;
            ior_r   <= {ior_r[1:0], IOR_N};
            iow_r   <= {iow_r[1:0], IOW_N};
            pa_s1_r <= FIRST_PORT_LINES_IN;
            pa_s2_r <= pa_s1_r;
            pb_s1_r <= SECOND_PORT_LINES_IN;
            pb_s2_r <= pb_s1_r;
            pc_s1_r <= THIRD_PORT_LINES_IN;
            pc_s2_r <= pc_s1_r;
        end
    end

    // ------------------------------------------------------------
    // address decode and access events
    // ------------------------------------------------------------
    logic       hit;      // address inside the block
    logic [2:0] ofs;      // offset in the block
    logic       rd_act;   // read strobe active (synced)
    logic       rd_ev;    // read strobe start
    logic       wr_ev;    // write strobe start

    assign hit    = (sa_s2_r[9:3] == bs_s2_r);
    assign ofs    = sa_s2_r[2:0];
    assign rd_act = ~ior_r[1];
    assign rd_ev  = ~ior_r[1] & ior_r[2] & hit;
    assign wr_ev  = ~iow_r[1] & iow_r[2] & hit;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    cdio_pkg::cdio_chan_t [2:0] ch_r, ch_nxt;  // timer channels
    logic [4:0] dir_r, dir_nxt;  // direction bits 4..0, one = input
    logic [7:0] pa_r,  pa_nxt;   // port A output latch
    logic [7:0] pb_r,  pb_nxt;   // port B output latch
    logic [7:0] pc_r,  pc_nxt;   // port C output latch
    logic [7:0] rd_r,  rd_nxt;   // read data held for the bus
    logic [7:0] pa_oe, pb_oe, pc_oe; // per-line drive enables

    // drive enables from the direction bits
    assign pa_oe = {8{~dir_r[`CDIO_DIR_A]}};
    assign pb_oe = {8{~dir_r[`CDIO_DIR_B]}};
    assign pc_oe = {{4{~dir_r[`CDIO_DIR_CHI]}},
                    {4{~dir_r[`CDIO_DIR_CLO]}}};

    // next state for all bus-visible registers
    always_comb
    begin
        cdio_pkg::cdio_chan_t c;
        logic [1:0]           sel;
        c       = '0;
        sel     = 2'h0;
        ch_nxt  = ch_r;
        dir_nxt = dir_r;
        pa_nxt  = pa_r;
        pb_nxt  = pb_r;
        pc_nxt  = pc_r;
        rd_nxt  = rd_r;
        if (wr_ev)
        begin
            case (ofs)
                `CDIO_OFS_TMR0, `CDIO_OFS_TMR1, `CDIO_OFS_TMR2:
                begin
                    // divisor load by the access format
                    c = ch_r[ofs[1:0]];
                    case (c.fmt)
                        `CDIO_FMT_MSB: c.cfg.divisor[15:8] = sd_s2_r;
                        `CDIO_FMT_BOTH:
                        begin
                            if (c.wr_hi)
                                c.cfg.divisor[15:8] = sd_s2_r;
                            else
                                c.cfg.divisor[7:0] = sd_s2_r;
                            c.wr_hi = ~c.wr_hi;
                        end
                        default: c.cfg.divisor[7:0] = sd_s2_r;
                    endcase
                    ch_nxt[ofs[1:0]] = c;
                end
                `CDIO_OFS_TCTRL:
                begin
                    sel = sd_s2_r[`CDIO_CW_SEL_HI:`CDIO_CW_SEL_LO];
                    if (sel == `CDIO_SEL_RDBACK)
                    begin
                        // read-back: low-active count bit, channel mask
                        for (int i = 0; i < 3; i++)
                            if (!sd_s2_r[5] && sd_s2_r[i + 1])
                                ch_nxt[i] = do_latch(ch_r[i]);
                    end
                    else if (sd_s2_r[`CDIO_CW_FMT_HI:`CDIO_CW_FMT_LO]
                             == `CDIO_FMT_LATCH)
                        ch_nxt[sel] = do_latch(ch_r[sel]);
                    else
                    begin
                        // new programming restarts both byte pointers
                        c          = ch_r[sel];
                        c.fmt      = sd_s2_r[`CDIO_CW_FMT_HI:`CDIO_CW_FMT_LO];
                        c.cfg.mode = dec_mode(
                            sd_s2_r[`CDIO_CW_MODE_HI:`CDIO_CW_MODE_LO]);
                        c.cfg.bcd  = sd_s2_r[`CDIO_CW_BCD];
                        c.latched  = 1'b0;
                        c.wr_hi    = 1'b0;
                        c.rd_hi    = 1'b0;
                        ch_nxt[sel] = c;
                    end
                end
                `CDIO_OFS_PORTA: pa_nxt = sd_s2_r;
                `CDIO_OFS_PORTB: pb_nxt = sd_s2_r;
                `CDIO_OFS_PORTC: pc_nxt = sd_s2_r;
                `CDIO_OFS_DIR:
                    dir_nxt = sd_s2_r[4:0];
                default: dir_nxt = dir_r;
            endcase
        end
        else if (rd_ev)
        begin
            case (ofs)
                `CDIO_OFS_TMR0, `CDIO_OFS_TMR1, `CDIO_OFS_TMR2:
                begin
                    // latched value first, else the loaded divisor
                    c = ch_r[ofs[1:0]];
                    if ((c.fmt == `CDIO_FMT_MSB) || c.rd_hi)
                        rd_nxt = c.latched ? c.latch[15:8]
                                           : c.cfg.divisor[15:8];
                    else
                        rd_nxt = c.latched ? c.latch[7:0]
                                           : c.cfg.divisor[7:0];
                    if ((c.fmt == `CDIO_FMT_BOTH) && !c.rd_hi)
                        c.rd_hi = 1'b1;
                    else
                    begin
                        c.rd_hi   = 1'b0;
                        c.latched = 1'b0;
                    end
                    ch_nxt[ofs[1:0]] = c;
                end
                `CDIO_OFS_PORTA: rd_nxt = mix(pa_r, pa_s2_r, pa_oe);
                `CDIO_OFS_PORTB: rd_nxt = mix(pb_r, pb_s2_r, pb_oe);
                `CDIO_OFS_PORTC:
                    rd_nxt = mix(pc_r, pc_s2_r, pc_oe);
                default: rd_nxt = `CDIO_WO_READ;
            endcase
        end
    end

    // register all bus-visible state
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            for (int i = 0; i < 3; i++)
            begin
                ch_r[i]     <= '0;
                ch_r[i].fmt <= `CDIO_FMT_BOTH;
            end
            dir_r <= {5{`CDIO_DIR_RST}};
            pa_r  <= `CDIO_PORT_RST;
            pb_r  <= `CDIO_PORT_RST;
            pc_r  <= `CDIO_PORT_RST;
            rd_r  <= 8'h00;
        end
        else
        begin
            ch_r  <= ch_nxt;
            dir_r <= dir_nxt;
            pa_r  <= pa_nxt;
            pb_r  <= pb_nxt;
            pc_r  <= pc_nxt;
            rd_r  <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // only plain latched drive, no handshake lines
    assign FIRST_PORT_LINES_OUT  = pa_r;
    assign FIRST_PORT_LINES_OE   = pa_oe;
    assign SECOND_PORT_LINES_OUT = pb_r;
    assign SECOND_PORT_LINES_OE  = pb_oe;
    assign THIRD_PORT_LINES_OUT  = pc_r;
    assign THIRD_PORT_LINES_OE   = pc_oe;
    assign SD_OUT                = rd_r;
    // drive the bus one cycle after the read start, while it stays active
    assign SD_OE = rd_act & ~ior_r[2] & hit;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            TIMER_CFG[i] = ch_r[i].cfg;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    no_foreign_drive_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        !hit |-> !SD_OE) else $error("bus driven outside block");
    dir_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_ev && ofs == `CDIO_OFS_DIR |=> dir_r == $past(sd_s2_r[4:0]))
        else $error("direction write lost");
    dir_0x92_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_ev && ofs == `CDIO_OFS_DIR && sd_s2_r == 8'h92 |=>
        FIRST_PORT_LINES_OE == 8'h00 && SECOND_PORT_LINES_OE == 8'h00 &&
        THIRD_PORT_LINES_OE == 8'hFF)
        else $error("0x92 direction wrong");
    out_drive_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_ev && ofs == `CDIO_OFS_PORTA |=>
        FIRST_PORT_LINES_OUT == $past(sd_s2_r))
        else $error("port A not latched");
    out_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        !(wr_ev && ofs == `CDIO_OFS_PORTB) |=> $stable(SECOND_PORT_LINES_OUT))
        else $error("port B changed without write");
    in_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        rd_ev && ofs == `CDIO_OFS_PORTC |=>
        (SD_OUT & ~$past(pc_oe)) == ($past(pc_s2_r) & ~$past(pc_oe)))
        else $error("port C input read");
    nibble_split_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        THIRD_PORT_LINES_OE[3:0] == {4{~dir_r[`CDIO_DIR_CLO]}} &&
        THIRD_PORT_LINES_OE[7:4] == {4{~dir_r[`CDIO_DIR_CHI]}})
        else $error("port C nibble enable");
    reset_hiz_a: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> FIRST_PORT_LINES_OE == 8'h00 &&
        SECOND_PORT_LINES_OE == 8'h00 && THIRD_PORT_LINES_OE == 8'h00)
        else $error("port driven after reset");
    wo_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        rd_ev && ofs == `CDIO_OFS_DIR |=> $stable(dir_r) && $stable(ch_r))
        else $error("write-only read changed state");
    cw_mode_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_ev && ofs == `CDIO_OFS_TCTRL && sd_s2_r[7:4] == 4'h5 &&
        sd_s2_r[2:1] == 2'h3 |=>
        TIMER_CFG[1].mode == cdio_pkg::CDIO_M_SQUARE &&
        TIMER_CFG[1].bcd == $past(sd_s2_r[0]))
        else $error("control word decode");

endmodule
`default_nettype wire

// [hw/cdio_defs.svh]
// Purpose: offsets, field positions and reset values of the counter/DIO port
// Assumes: included by bare name from the design module only
// Notes:   definitions only
`ifndef CDIO_DEFS_SVH
`define CDIO_DEFS_SVH

// register offsets inside the eight-address block
`define CDIO_OFS_TMR0      3'h0
`define CDIO_OFS_TMR1      3'h1
`define CDIO_OFS_TMR2      3'h2
`define CDIO_OFS_TCTRL     3'h3
`define CDIO_OFS_PORTA     3'h4
`define CDIO_OFS_PORTB     3'h5
`define CDIO_OFS_PORTC     3'h6
`define CDIO_OFS_DIR       3'h7

// direction register bit positions
`define CDIO_DIR_A         4
`define CDIO_DIR_B         1
`define CDIO_DIR_CHI       3
`define CDIO_DIR_CLO       0

// timer control word field positions
`define CDIO_CW_SEL_HI     7
`define CDIO_CW_SEL_LO     6
`define CDIO_CW_FMT_HI     5
`define CDIO_CW_FMT_LO     4
`define CDIO_CW_MODE_HI    3
`define CDIO_CW_MODE_LO    1
`define CDIO_CW_BCD        0

// selector and access format codes
`define CDIO_SEL_RDBACK    2'h3
`define CDIO_FMT_LATCH     2'h0
`define CDIO_FMT_LSB       2'h1
`define CDIO_FMT_MSB       2'h2
`define CDIO_FMT_BOTH      2'h3

// reset values and the byte read at write-only offsets
`define CDIO_DIR_RST       1'h1
`define CDIO_PORT_RST      8'h00
`define CDIO_WO_READ       8'hFF

`endif

// [hw/cdio_pkg.sv]
// Purpose: shared types of the counter/DIO register port
// Assumes: nothing
// Notes:   constants live in cdio_defs.svh
package cdio_pkg;

    // decoded timer operating mode
    typedef enum logic [2:0] {
        CDIO_M_TC_INT,
        CDIO_M_ONESHOT,
        CDIO_M_RATE,
        CDIO_M_SQUARE,
        CDIO_M_SW_STROBE,
        CDIO_M_HW_STROBE
    } cdio_mode_t;

    // configuration seen by the counting logic
    typedef struct packed {
        cdio_mode_t  mode;    // operating mode
        logic        bcd;     // one: four decimal digits
        logic [15:0] divisor; // loaded divisor
    } cdio_tcfg_t;

    // per-channel register state
    typedef struct packed {
        cdio_tcfg_t  cfg;     // configuration
        logic [1:0]  fmt;     // byte access format
        logic [15:0] latch;   // latched count
        logic        latched; // latch holds a count
        logic        wr_hi;   // next write is the high byte
        logic        rd_hi;   // next read is the high byte
    } cdio_chan_t;

endpackage

// [sim/cdio_host.sv]
// Purpose: host bus model that drives the counter/DIO register port
// Assumes: strobe and setup spacing as the port's sync stages need
// Notes:   read data and drive flag are taken while the strobe is low
`timescale 1ns/100ps
`default_nettype none
module cdio_host
(
    input  wire logic       REF_CLK, // system clock
    output var  logic [9:0] SA,      // bus address
    output var  logic       IOR_N,   // read strobe, low
    output var  logic       IOW_N,   // write strobe, low
    output var  logic [7:0] SD_IN,   // write data
    input  wire logic [7:0] SD_OUT,  // read data
    input  wire logic       SD_OE    // read data drive
);
    // idle bus: strobes high from time zero
    initial
    begin
        SA    = 10'h000;
        IOR_N = 1'b1;
        IOW_N = 1'b1;
        SD_IN = 8'h00;
    end
    // one write; address and data settle three cycles before the strobe
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        SA    <= a;
        SD_IN <= d;
        repeat (3) @(posedge REF_CLK);
        IOW_N <= 1'b0;
        repeat (6) @(posedge REF_CLK);
        IOW_N <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        // released data bus shows the inverse, never a stale copy
        SD_IN <= ~d;
    endtask
    // one read; q is taken at the last edge of the strobe
    task automatic rd(input logic [9:0] a, output logic [7:0] q,
                      output logic oe);
        oe = 1'b0;
        @(posedge REF_CLK);
        SA <= a;
        repeat (3) @(posedge REF_CLK);
        IOR_N <= 1'b0;
        repeat (6)
        begin
            @(posedge REF_CLK);
            oe = oe | SD_OE;
        end
        q = SD_OUT;
        IOR_N <= 1'b1;
        repeat (4) @(posedge REF_CLK);
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: register-level checks of the counter/DIO register port
// Assumes: block decoded at 0x220; undriven field lines read a_ext, b_ext, c_ext values
// Notes:   counting itself is not modelled, only the configuration
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk, reset;            // clock and async reset
    logic [6:0] base_sel;            // base switches
    wire logic [9:0] sa;             // host address
    wire logic ior_n, iow_n;         // host strobes
    wire logic [7:0] sd_in;          // host write data
    logic [7:0] sd_out;              // read data
    logic sd_oe;                     // read drive
    logic [7:0] a_ext, b_ext, c_ext; // far-end levels on undriven lines
    wire logic [7:0] a_in, b_in, c_in;
    logic [7:0] a_out, b_out, c_out, a_oe, b_oe, c_oe;
    cdio_pkg::cdio_tcfg_t [2:0] tcfg;
    int bad_count, total_checks;
    logic [7:0] q;                   // read result
    logic oe;                        // drive seen during a read
    logic [2:0] m3;                  // mode code under test
    localparam logic [9:0] BASE = 10'h220;
    // direction values with the enables they must give
    logic [7:0]  dir_val [6] = '{8'h92, 8'hEF, 8'hFD, 8'hF7, 8'hFE, 8'hE4};
    logic [15:0] dir_ab  [6] = '{16'h0, 16'hFF00, 16'h00FF, 16'h0, 16'h0,
                                 16'hFFFF};
    logic [7:0]  dir_c   [6] = '{8'hFF, 8'h00, 8'h00, 8'hF0, 8'h0F, 8'hFF};
    cdio_pkg::cdio_mode_t mode_tbl [8] = '{cdio_pkg::CDIO_M_TC_INT,
        cdio_pkg::CDIO_M_ONESHOT, cdio_pkg::CDIO_M_RATE,
        cdio_pkg::CDIO_M_SQUARE, cdio_pkg::CDIO_M_SW_STROBE,
        cdio_pkg::CDIO_M_HW_STROBE, cdio_pkg::CDIO_M_RATE,
        cdio_pkg::CDIO_M_SQUARE};
    // ----------------------------------------------------------------
    // wire levels: a driven line shows the latch, else the far end
    // ----------------------------------------------------------------
    assign a_in = (a_oe & a_out) | (~a_oe & a_ext);
    assign b_in = (b_oe & b_out) | (~b_oe & b_ext);
    assign c_in = (c_oe & c_out) | (~c_oe & c_ext);
    cdio_port u_cdio_port (.REF_CLK(ref_clk), .RESET(reset), .SA(sa),
        .BASE_SEL(base_sel), .IOR_N(ior_n), .IOW_N(iow_n), .SD_IN(sd_in),
        .SD_OUT(sd_out), .SD_OE(sd_oe), .FIRST_PORT_LINES_IN(a_in),
        .FIRST_PORT_LINES_OUT(a_out), .FIRST_PORT_LINES_OE(a_oe),
        .SECOND_PORT_LINES_IN(b_in), .SECOND_PORT_LINES_OUT(b_out),
        .SECOND_PORT_LINES_OE(b_oe), .THIRD_PORT_LINES_IN(c_in),
        .THIRD_PORT_LINES_OUT(c_out), .THIRD_PORT_LINES_OE(c_oe),
        .TIMER_CFG(tcfg));
    cdio_host u_cdio_host (.REF_CLK(ref_clk), .SA(sa), .IOR_N(ior_n),
        .IOW_N(iow_n), .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE(sd_oe));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard: a run this long counts as a failure
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        results();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        base_sel = 7'h44;
        a_ext = 8'h3C;
        b_ext = 8'hC3;
        c_ext = 8'h96;
        bad_count = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({a_oe, b_oe}, 16'h0000);
        chk(c_oe, 8'h00);
        // 0x92, then each direction bit cleared alone, then only ignored bits set
        for (int i = 0; i < 6; i++)
        begin
            u_cdio_host.wr(BASE + 10'h7, dir_val[i]);
            chk({a_oe, b_oe}, dir_ab[i]);
            chk(c_oe, dir_c[i]);
        end
        // all outputs: latches reach the lines, port A reads back
        u_cdio_host.wr(BASE + 10'h4, 8'h5A);
        u_cdio_host.wr(BASE + 10'h5, 8'hA5);
        u_cdio_host.wr(BASE + 10'h6, 8'h81);
        chk({a_out, b_out}, 16'h5AA5);
        chk(c_out, 8'h81);
        u_cdio_host.rd(BASE + 10'h4, q, oe);
        chk(q, 8'h5A);
        // A and B inputs, C still outputs with its latch kept
        u_cdio_host.wr(BASE + 10'h7, 8'h92);
        chk(c_out, 8'h81);
        u_cdio_host.rd(BASE + 10'h4, q, oe);
        chk(q, 8'h3C);
        u_cdio_host.rd(BASE + 10'h5, q, oe);
        chk(q, 8'hC3);
        @(posedge ref_clk);
        a_ext <= 8'h0F;
        u_cdio_host.rd(BASE + 10'h4, q, oe);
        chk(q, 8'h0F);
        // upper C out, lower C in: halves act on their own
        u_cdio_host.wr(BASE + 10'h7, 8'hF7);
        u_cdio_host.wr(BASE + 10'h6, 8'hA5);
        u_cdio_host.rd(BASE + 10'h6, q, oe);
        chk(q, 8'hA6);
        // write-only places read FF and leave state alone
        u_cdio_host.rd(BASE + 10'h7, q, oe);
        chk(q, 8'hFF);
        u_cdio_host.rd(BASE + 10'h3, q, oe);
        chk(q, 8'hFF);
        chk(c_oe, 8'hF0);
        // the next block up is not ours: no write, no drive
        u_cdio_host.wr(BASE + 10'hE, 8'h00);
        chk(c_out, 8'hA5);
        u_cdio_host.rd(BASE + 10'hF, q, oe);
        chk(oe, 1'b0);
        // channel 0: rate mode, binary, low then high byte
        u_cdio_host.wr(BASE + 10'h3, 8'h34);
        u_cdio_host.wr(BASE + 10'h0, 8'hCD);
        u_cdio_host.wr(BASE + 10'h0, 8'hAB);
        chk(tcfg[0].divisor, 16'hABCD);
        chk(tcfg[0].mode, cdio_pkg::CDIO_M_RATE);
        chk(tcfg[0].bcd, 1'b0);
        // plain read, count latch, then read-back latch of channel 0
        for (int k = 0; k < 3; k++)
        begin
            if (k == 1)
                u_cdio_host.wr(BASE + 10'h3, 8'h00);
            if (k == 2)
                u_cdio_host.wr(BASE + 10'h3, 8'hC2);
            u_cdio_host.rd(BASE + 10'h0, q, oe);
            chk(q, 8'hCD);
            u_cdio_host.rd(BASE + 10'h0, q, oe);
            chk(q, 8'hAB);
        end
        // channel 1, low byte only: every mode code, bcd follows bit 0
        for (int i = 0; i < 8; i++)
        begin
            m3 = i[2:0];
            u_cdio_host.wr(BASE + 10'h3, {4'h5, m3, m3[0]});
            u_cdio_host.wr(BASE + 10'h1, 8'h10 + 8'(i));
            chk(tcfg[1].mode, mode_tbl[i]);
            chk(tcfg[1].bcd, m3[0]);
            chk(tcfg[1].divisor[7:0], 8'h10 + 8'(i));
        end
        // channel 2, high byte only; channel 0 untouched
        u_cdio_host.wr(BASE + 10'h3, 8'hA0);
        u_cdio_host.wr(BASE + 10'h2, 8'h77);
        chk(tcfg[2].divisor[15:8], 8'h77);
        chk(tcfg[0].divisor, 16'hABCD);
        results();
    end
endmodule
`default_nettype wire
